// *** sbiu_lmb_port.sv ***
`timescale 1ns/1ps
`default_nettype none

package sbiu_pkg;
    localparam int SBIU_ADDR_W = 32;
    localparam int SBIU_DATA_W = 32;
    localparam int SBIU_BE_W = 4;
    // Transfer size codes from the core
    localparam logic [1:0] SBIU_SIZE_BYTE = 2'h0;
    localparam logic [1:0] SBIU_SIZE_HALF = 2'h1;
    localparam logic [1:0] SBIU_SIZE_WORD = 2'h2;
    // Byte enable patterns, lane 0 (most significant byte) in the top bit
    localparam logic [3:0] SBIU_BE_NONE = 4'h0;
    localparam logic [3:0] SBIU_BE_LANE0 = 4'h8;
    localparam logic [3:0] SBIU_BE_LANE1 = 4'h4;
    localparam logic [3:0] SBIU_BE_LANE2 = 4'h2;
    localparam logic [3:0] SBIU_BE_LANE3 = 4'h1;
    localparam logic [3:0] SBIU_BE_HALF_HI = 4'hC;
    localparam logic [3:0] SBIU_BE_HALF_LO = 4'h3;
    localparam logic [3:0] SBIU_BE_WORD = 4'hF;
    localparam logic [31:0] SBIU_ZERO_WORD = 32'h0000_0000;
    localparam logic [31:0] SBIU_LOCAL_BASE = 32'h0000_0000;
    localparam logic [31:0] SBIU_LOCAL_MASK = 32'hFFFF_0000;

    typedef enum logic [2:0] {
        SBIU_PB_IDLE = 3'h1,
        SBIU_PB_ARB = 3'h2,
        SBIU_PB_XFER = 3'h4
    } sbiu_pb_state_e;

    // Misaligned accesses are forced onto the aligned lane group
    function automatic logic [3:0] sbiu_byte_enables(input logic [1:0] lo,
                                                     input logic [1:0] size);
        logic [3:0] be;
        be = SBIU_BE_WORD;
        if (size == SBIU_SIZE_BYTE) begin
            case (lo)
                2'h0: be = SBIU_BE_LANE0;
                2'h1: be = SBIU_BE_LANE1;
                2'h2: be = SBIU_BE_LANE2;
                default: be = SBIU_BE_LANE3;
            endcase
        end else if (size == SBIU_SIZE_HALF) begin
            be = lo[1] ? SBIU_BE_HALF_LO : SBIU_BE_HALF_HI;
        end
        return be;
    endfunction

    function automatic logic sbiu_be_legal(input logic [3:0] be);
        return (be == SBIU_BE_LANE0) || (be == SBIU_BE_LANE1) || (be == SBIU_BE_LANE2) ||
               (be == SBIU_BE_LANE3) || (be == SBIU_BE_HALF_HI) ||
               (be == SBIU_BE_HALF_LO) || (be == SBIU_BE_WORD);
    endfunction

    function automatic logic sbiu_is_local(input logic [31:0] addr,
                                           input logic [31:0] base,
                                           input logic [31:0] mask);
        return (addr & mask) == (base & mask);
    endfunction
endpackage

module sbiu_local_port import sbiu_pkg::*; (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [31:0] req_addr_i,
    input wire logic [3:0] req_be_i,
    input wire logic [31:0] req_wdata_i,
    output logic req_ready_o,
    output logic busy_o,
    output logic done_o,
    output logic [31:0] addr_o,
    output logic [3:0] be_o,
    output logic [31:0] wdata_o,
    output logic as_o,
    output logic rd_strobe_o,
    output logic wr_strobe_o,
    input wire logic ready_i
);
    logic take;

    assign busy_o = rd_strobe_o | wr_strobe_o;
    // A new transfer may start in the cycle the old one completes
    assign req_ready_o = !busy_o || ready_i;
    assign take = req_valid_i && req_ready_o;
    assign done_o = busy_o && ready_i;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            as_o <= 1'b0;
        end else begin
            as_o <= take;
        end
    end

    // Strobes stay up across back-to-back transfers of the same kind
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_strobe_o <= 1'b0;
            wr_strobe_o <= 1'b0;
        end else if (take) begin
            rd_strobe_o <= !req_write_i;
            wr_strobe_o <= req_write_i;
        end else if (done_o) begin
            rd_strobe_o <= 1'b0;
            wr_strobe_o <= 1'b0;
        end
    end

    // Held past the strobe cycle so a slow slave can still capture them
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_o <= SBIU_ZERO_WORD;
            be_o <= SBIU_BE_NONE;
            wdata_o <= SBIU_ZERO_WORD;
        end else if (take) begin
            addr_o <= req_addr_i;
            be_o <= req_be_i;
            wdata_o <= req_wdata_i;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_as_single_cycle: assert property (as_o && !ready_i |=> !as_o)
        else $error("address strobe held past first cycle");
    a_as_has_strobe: assert property (as_o |-> (rd_strobe_o ^ wr_strobe_o))
        else $error("address strobe without exactly one strobe");
    a_strobe_holds: assert property (busy_o && !ready_i |=> $stable({rd_strobe_o, wr_strobe_o})
                                     && !as_o)
        else $error("strobe changed before ready");
    a_strobe_releases: assert property (done_o && !req_valid_i |=> !busy_o && !as_o)
        else $error("strobe not released after ready");
    a_back_to_back: assert property (done_o && req_valid_i |=> as_o && busy_o)
        else $error("back-to-back transfer not started");
endmodule // sbiu_local_port

`default_nettype wire

// *** sbiu_top.sv ***
// How it works
// - Local bus reaches block RAM in one cycle; transfers may run back to back.
// - Every local bus control and data signal is active high.
// - Local address carries the transfer target; valid while address strobe is high.
// - Local address is guaranteed only in a transfer's first cycle.
// - Four byte enables mark valid lanes, valid with the address strobe only.
// - Only permitted byte enable patterns are emitted, single lanes for bytes.
// - Instruction local port has address, strobe, fetch flag, instruction and ready only.
// - Peripheral ports are byte enable masters without dynamic bus sizing.
// - Peripheral ports have separate write data output and read data input.
// - Instruction peripheral port write data is always all zeros.
// - Instruction peripheral port read-not-write is held at one.
// - Address strobe is high only in a transfer's first cycle.
// - Read or write strobe holds until the cycle after ready, longer if back to back with a transfer of the same kind.
`timescale 1ns/1ps
`default_nettype none

module sbiu_top import sbiu_pkg::*; #(
    parameter logic [31:0] LOCAL_BASE = SBIU_LOCAL_BASE,
    parameter logic [31:0] LOCAL_MASK = SBIU_LOCAL_MASK
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic dreq_valid_i,
    output logic dreq_ready_o,
    input wire logic dreq_write_i,
    input wire logic [31:0] dreq_addr_i,
    input wire logic [1:0] dreq_size_i,
    input wire logic [31:0] dreq_wdata_i,
    output logic drsp_valid_o,
    output logic [31:0] drsp_rdata_o,
    output logic drsp_err_o,
    input wire logic ireq_valid_i,
    output logic ireq_ready_o,
    input wire logic [31:0] ireq_addr_i,
    output logic irsp_valid_o,
    output logic [31:0] irsp_instr_o,
    output logic irsp_err_o,
    output logic [31:0] data_addr_o,
    output logic [3:0] data_byte_en_o,
    output logic [31:0] data_wdata_o,
    output logic data_addr_strobe_o,
    output logic data_read_strobe_o,
    output logic data_write_strobe_o,
    input wire logic [31:0] data_rdata_i,
    input wire logic data_side_ready_i,
    output logic [31:0] instr_addr_o,
    output logic instr_addr_strobe_o,
    output logic fetch_in_progress_o,
    input wire logic [31:0] instr_word_i,
    input wire logic instr_side_ready_i,
    output logic [31:0] dpb_addr_o,
    output logic [3:0] dpb_byte_en_o,
    output logic dpb_bus_lock_o,
    output logic [31:0] dpb_wdata_o,
    output logic dpb_request_o,
    output logic dpb_read_not_write_o,
    output logic dpb_select_o,
    output logic dpb_seq_addr_o,
    input wire logic [31:0] dpb_rdata_i,
    input wire logic dpb_err_ack_i,
    input wire logic dpb_grant_i,
    input wire logic dpb_retry_i,
    input wire logic dpb_timeout_i,
    input wire logic dpb_xfer_ack_i,
    output logic [31:0] ipb_addr_o,
    output logic [3:0] ipb_byte_en_o,
    output logic ipb_bus_lock_o,
    output logic [31:0] instr_port_wdata_o,
    output logic ipb_request_o,
    output logic instr_port_read_not_write_o,
    output logic ipb_select_o,
    output logic ipb_seq_addr_o,
    input wire logic [31:0] ipb_rdata_i,
    input wire logic ipb_err_ack_i,
    input wire logic ipb_grant_i,
    input wire logic ipb_retry_i,
    input wire logic ipb_timeout_i,
    input wire logic ipb_xfer_ack_i
);
    // Index 0 is the data side, index 1 the instruction side
    logic d_local;
    logic i_local;
    logic [3:0] d_be;
    logic dl_ready;
    logic dl_busy;
    logic dl_done;
    logic dl_free;
    logic il_ready;
    logic il_busy;
    logic il_done;
    logic il_free;
    logic [1:0] pb_take;
    logic [1:0] pb_done;
    logic [1:0] pb_err;
    logic [1:0] pb_idle;
    logic [1:0] pb_rnw_in;
    logic [1:0] pb_grant;
    logic [1:0] pb_xack;
    logic [1:0] pb_eack;
    logic [1:0] pb_tout;
    logic [1:0] pb_retry;
    logic [1:0] pb_request;
    logic [1:0] pb_select;
    logic [1:0] pb_rnw_q;
    logic [31:0] pb_addr_in [2];
    logic [31:0] pb_wdata_in [2];
    logic [3:0] pb_be_in [2];
    logic [31:0] pb_addr_q [2];
    logic [31:0] pb_wdata_q [2];
    logic [3:0] pb_be_q [2];

    assign d_local = sbiu_is_local(dreq_addr_i, LOCAL_BASE, LOCAL_MASK);
    assign i_local = sbiu_is_local(ireq_addr_i, LOCAL_BASE, LOCAL_MASK);
    assign d_be = sbiu_byte_enables(dreq_addr_i[1:0], dreq_size_i);
    assign dl_free = dl_ready;
    assign il_free = il_ready;

    // One outstanding transfer per side keeps answers in request order
    assign dreq_ready_o = dl_free && pb_idle[0];
    assign ireq_ready_o = il_free && pb_idle[1];

    sbiu_local_port u_data_local (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .req_valid_i(dreq_valid_i && d_local && pb_idle[0]),
        .req_write_i(dreq_write_i),
        .req_addr_i(dreq_addr_i),
        .req_be_i(d_be),
        .req_wdata_i(dreq_wdata_i),
        .req_ready_o(dl_ready),
        .busy_o(dl_busy),
        .done_o(dl_done),
        .addr_o(data_addr_o),
        .be_o(data_byte_en_o),
        .wdata_o(data_wdata_o),
        .as_o(data_addr_strobe_o),
        .rd_strobe_o(data_read_strobe_o),
        .wr_strobe_o(data_write_strobe_o),
        .ready_i(data_side_ready_i)
    );

    // Fetch side leaves byte enables, write data and write strobe open
    sbiu_local_port u_instr_local (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .req_valid_i(ireq_valid_i && i_local && pb_idle[1]),
        .req_write_i(1'b0),
        .req_addr_i(ireq_addr_i),
        .req_be_i(SBIU_BE_WORD),
        .req_wdata_i(SBIU_ZERO_WORD),
        .req_ready_o(il_ready),
        .busy_o(il_busy),
        .done_o(il_done),
        .addr_o(instr_addr_o),
        .be_o(),
        .wdata_o(),
        .as_o(instr_addr_strobe_o),
        .rd_strobe_o(fetch_in_progress_o),
        .wr_strobe_o(),
        .ready_i(instr_side_ready_i)
    );

    assign pb_take[0] = dreq_valid_i && !d_local && dl_free && pb_idle[0];
    assign pb_take[1] = ireq_valid_i && !i_local && il_free && pb_idle[1];
    assign pb_addr_in[0] = dreq_addr_i;
    assign pb_addr_in[1] = ireq_addr_i;
    assign pb_be_in[0] = d_be;
    assign pb_be_in[1] = SBIU_BE_WORD;
    assign pb_rnw_in = {1'b1, !dreq_write_i};
    assign pb_wdata_in[0] = dreq_wdata_i;
    assign pb_wdata_in[1] = SBIU_ZERO_WORD;
    assign pb_grant = {ipb_grant_i, dpb_grant_i};
    assign pb_xack = {ipb_xfer_ack_i, dpb_xfer_ack_i};
    assign pb_eack = {ipb_err_ack_i, dpb_err_ack_i};
    assign pb_tout = {ipb_timeout_i, dpb_timeout_i};
    assign pb_retry = {ipb_retry_i, dpb_retry_i};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    for (genvar g = 0; g < 2; g++) begin : g_pb
        sbiu_pb_state_e state;
        sbiu_pb_state_e next_state;
        logic [31:0] lat_addr;
        logic [31:0] lat_wdata;
        logic [3:0] lat_be;
        logic lat_rnw;
        logic ended;

        assign ended = pb_xack[g] || pb_eack[g] || pb_tout[g];
        assign pb_idle[g] = (state == SBIU_PB_IDLE);
        assign pb_done[g] = (state == SBIU_PB_XFER) && ended;
        assign pb_err[g] = (state == SBIU_PB_XFER) && (pb_eack[g] || pb_tout[g]);

        always_comb begin
            next_state = state;
            unique case (state)
                SBIU_PB_IDLE: if (pb_take[g]) next_state = SBIU_PB_ARB;
                SBIU_PB_ARB: if (pb_grant[g]) next_state = SBIU_PB_XFER;
                SBIU_PB_XFER: begin
                    // Acknowledge wins over a retry seen in the same cycle
                    if (ended) begin
                        next_state = SBIU_PB_IDLE;
                    end else if (pb_retry[g]) begin
                        next_state = SBIU_PB_ARB;
                    end
                end
                default: next_state = SBIU_PB_IDLE;
            endcase
        end

        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                state <= SBIU_PB_IDLE;
            end else begin
                state <= next_state;
            end
        end

        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                lat_addr <= SBIU_ZERO_WORD;
                lat_wdata <= SBIU_ZERO_WORD;
                lat_be <= SBIU_BE_NONE;
                lat_rnw <= 1'b1;
            end else if (pb_take[g]) begin
                lat_addr <= pb_addr_in[g];
                lat_wdata <= pb_wdata_in[g];
                lat_be <= pb_be_in[g];
                lat_rnw <= pb_rnw_in[g];
            end
        end

        // Unselected masters drive zeros so buses can be ORed, except the fetch port's read-not-write, held at one
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                pb_request[g] <= 1'b0;
                pb_select[g] <= 1'b0;
                pb_addr_q[g] <= SBIU_ZERO_WORD;
                pb_wdata_q[g] <= SBIU_ZERO_WORD;
                pb_be_q[g] <= SBIU_BE_NONE;
                pb_rnw_q[g] <= 1'b0;
            end else begin
                pb_request[g] <= (next_state == SBIU_PB_ARB);
                pb_select[g] <= (next_state == SBIU_PB_XFER);
                if (next_state == SBIU_PB_XFER) begin
                    pb_addr_q[g] <= lat_addr;
                    pb_wdata_q[g] <= lat_rnw ? SBIU_ZERO_WORD : lat_wdata;
                    pb_be_q[g] <= lat_be;
                    pb_rnw_q[g] <= lat_rnw;
                end else begin
                    pb_addr_q[g] <= SBIU_ZERO_WORD;
                    pb_wdata_q[g] <= SBIU_ZERO_WORD;
                    pb_be_q[g] <= SBIU_BE_NONE;
                    pb_rnw_q[g] <= 1'b0;
                end
            end
        end

        sequence s_waiting;
            pb_request[g] && !pb_grant[g];
        endsequence
        sequence s_granted;
            pb_request[g] && pb_grant[g];
        endsequence

        a_no_select_ungranted: assert property (s_waiting |=> !pb_select[g])
            else $error("select raised without grant");
        a_select_after_grant: assert property (s_granted |=> pb_select[g] && !pb_request[g]
                                               && pb_be_q[g] != SBIU_BE_NONE)
            else $error("grant not followed by select");
        a_idle_bus_zero: assert property (!pb_select[g] |-> pb_addr_q[g] == SBIU_ZERO_WORD
                                          && pb_be_q[g] == SBIU_BE_NONE)
            else $error("unselected master drives bus");
        a_pb_be_legal: assert property (pb_select[g] |-> sbiu_be_legal(pb_be_q[g]))
            else $error("peripheral byte enables illegal");
    end

    assign dpb_addr_o = pb_addr_q[0];
    assign dpb_byte_en_o = pb_be_q[0];
    assign dpb_wdata_o = pb_wdata_q[0];
    assign dpb_request_o = pb_request[0];
    assign dpb_select_o = pb_select[0];
    assign dpb_read_not_write_o = pb_rnw_q[0];
    assign ipb_addr_o = pb_addr_q[1];
    assign ipb_byte_en_o = pb_be_q[1];
    assign ipb_request_o = pb_request[1];
    assign ipb_select_o = pb_select[1];
    // Single transfers only, so no locking and no sequential bursts
    assign dpb_bus_lock_o = 1'b0;
    assign dpb_seq_addr_o = 1'b0;
    assign ipb_bus_lock_o = 1'b0;
    assign ipb_seq_addr_o = 1'b0;
    // Constant so the fetch port looks like the data port; synthesis drops it
    assign instr_port_wdata_o = SBIU_ZERO_WORD;
    assign instr_port_read_not_write_o = 1'b1;

    // Answers are registered; read data captured on the ready edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            drsp_valid_o <= 1'b0;
            drsp_err_o <= 1'b0;
            drsp_rdata_o <= SBIU_ZERO_WORD;
        end else begin
            drsp_valid_o <= dl_done || pb_done[0];
            drsp_err_o <= pb_err[0];
            if (dl_done) begin
                drsp_rdata_o <= data_rdata_i;
            end else if (pb_done[0]) begin
                drsp_rdata_o <= dpb_rdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irsp_valid_o <= 1'b0;
            irsp_err_o <= 1'b0;
            irsp_instr_o <= SBIU_ZERO_WORD;
        end else begin
            irsp_valid_o <= il_done || pb_done[1];
            irsp_err_o <= pb_err[1];
            if (il_done) begin
                irsp_instr_o <= instr_word_i;
            end else if (pb_done[1]) begin
                irsp_instr_o <= ipb_rdata_i;
            end
        end
    end

    a_local_be_legal: assert property (data_addr_strobe_o |-> sbiu_be_legal(data_byte_en_o))
        else $error("local byte enables illegal");
    a_byte_single_lane: assert property (dreq_valid_i && dreq_ready_o && d_local
                                         && dreq_size_i == SBIU_SIZE_BYTE
                                         |=> $countones(data_byte_en_o) == 1)
        else $error("byte transfer without single lane");
    a_local_addr_taken: assert property (dreq_valid_i && dreq_ready_o && d_local
                                         |=> data_addr_strobe_o
                                         && data_addr_o == $past(dreq_addr_i))
        else $error("local address not presented with strobe");
    a_local_answer: assert property (dl_done ##1 1'b1 |-> drsp_valid_o && !drsp_err_o)
        else $error("local transfer not answered");
    a_fetch_answer: assert property (il_done |=> irsp_valid_o
                                     && irsp_instr_o == $past(instr_word_i))
        else $error("fetch data not returned");
    a_iport_const: assert property (instr_port_wdata_o == SBIU_ZERO_WORD
                                    && instr_port_read_not_write_o)
        else $error("instruction port constants wrong");
    a_one_target: assert property (!(dl_busy && !pb_idle[0]))
        else $error("data side has two outstanding transfers");
endmodule // sbiu_top

`default_nettype wire

// *** sbiu_bus_models.sv ***
`timescale 1ns/1ps
`default_nettype none

module sbiu_ram_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic [31:0] addr_i,
    input wire logic [3:0] be_i,
    input wire logic [31:0] wdata_i,
    input wire logic as_i,
    input wire logic wr_i,
    output logic [31:0] rdata_o,
    output logic ready_o
);
    logic [31:0] mem [0:255];
    logic [7:0] a;
    logic [3:0] be;
    logic [1:0] cnt = 2'h0;
    logic [7:0] ai;
    logic [3:0] bi;
    assign ai = as_i ? addr_i[9:2] : a;
    assign bi = as_i ? be_i : be;
    // Slow mode answers three cycles late, to exercise held strobes
    assign ready_o = (as_i && !slow_i) || cnt == 2'h1;
    // Off-ready data is inverted so a stale value cannot pass
    assign rdata_o = ready_o ? mem[ai] : ~mem[ai];
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = {4{i[7:0]}} ^ 32'h5A5A_A5A5;
    end
    always @(posedge clk_i) begin
        if (as_i) begin
            a <= addr_i[9:2];
            be <= be_i;
            cnt <= slow_i ? 2'h3 : 2'h0;
        end else if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end
        if (ready_o && wr_i) begin
            for (int k = 0; k < 4; k++) if (bi[k]) mem[ai][8*k+:8] <= wdata_i[8*k+:8];
        end
    end
endmodule // sbiu_ram_model

module sbiu_pb_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic req_i,
    input wire logic sel_i,
    input wire logic [31:0] addr_i,
    output logic grant_o,
    output logic ack_o,
    output logic err_o,
    output logic tout_o,
    output logic [31:0] rdata_o
);
    logic [1:0] w = 2'h0;
    logic done;
    assign grant_o = req_i;
    assign done = sel_i && w == (slow_i ? 2'h2 : 2'h0);
    // Bit 31 picks an error answer, bit 30 a timeout
    assign ack_o = done && addr_i[31:30] == 2'h0;
    assign err_o = done && addr_i[31];
    assign tout_o = done && addr_i[30] && !addr_i[31];
    // Idle slaves drive zero so the read buses can be ORed
    assign rdata_o = done ? ~addr_i : 32'h0000_0000;
    always @(posedge clk_i) w <= (sel_i && !done) ? w + 2'h1 : 2'h0;
endmodule // sbiu_pb_model

`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench import sbiu_pkg::*; ;
    logic clk_i = 0, arst_n_i = 0, slow = 0;
    logic dreq_valid_i = 0, dreq_write_i = 0, ireq_valid_i = 0;
    logic [1:0] dreq_size_i = 0;
    logic [31:0] dreq_addr_i = 0, dreq_wdata_i = 0, ireq_addr_i = 0;
    wire logic dreq_ready_o, drsp_valid_o, drsp_err_o, ireq_ready_o, irsp_valid_o, irsp_err_o;
    wire logic data_addr_strobe_o, data_read_strobe_o, data_write_strobe_o, data_side_ready_i;
    wire logic instr_addr_strobe_o, fetch_in_progress_o, instr_side_ready_i;
    wire logic dpb_request_o, dpb_select_o, dpb_err_ack_i, dpb_grant_i, dpb_xfer_ack_i;
    wire logic ipb_request_o, ipb_select_o, ipb_err_ack_i, ipb_grant_i, ipb_xfer_ack_i;
    wire logic instr_port_read_not_write_o, dpb_timeout_i, ipb_timeout_i;
    wire logic [3:0] data_byte_en_o;
    wire logic [31:0] drsp_rdata_o, irsp_instr_o, data_addr_o, data_wdata_o, data_rdata_i;
    wire logic [31:0] instr_addr_o, instr_word_i, dpb_addr_o, dpb_rdata_i, ipb_addr_o;
    wire logic [31:0] ipb_rdata_i, instr_port_wdata_o;
    logic [33:0] dq[$], iq[$];
    int bad_count = 0, n_checks = 0;

    sbiu_top uut (.clk_i, .arst_n_i, .dreq_valid_i, .dreq_ready_o, .dreq_write_i, .dreq_addr_i,
        .dreq_size_i, .dreq_wdata_i, .drsp_valid_o, .drsp_rdata_o, .drsp_err_o, .ireq_valid_i,
        .ireq_ready_o, .ireq_addr_i, .irsp_valid_o, .irsp_instr_o, .irsp_err_o, .data_addr_o,
        .data_byte_en_o, .data_wdata_o, .data_addr_strobe_o, .data_read_strobe_o,
        .data_write_strobe_o, .data_rdata_i, .data_side_ready_i, .instr_addr_o,
        .instr_addr_strobe_o, .fetch_in_progress_o, .instr_word_i, .instr_side_ready_i,
        .dpb_addr_o, .dpb_byte_en_o(), .dpb_bus_lock_o(), .dpb_wdata_o(), .dpb_request_o,
        .dpb_read_not_write_o(), .dpb_select_o, .dpb_seq_addr_o(), .dpb_rdata_i,
        .dpb_err_ack_i, .dpb_grant_i, .dpb_retry_i(1'b0), .dpb_timeout_i,
        .dpb_xfer_ack_i, .ipb_addr_o, .ipb_byte_en_o(), .ipb_bus_lock_o(), .instr_port_wdata_o,
        .ipb_request_o, .instr_port_read_not_write_o, .ipb_select_o, .ipb_seq_addr_o(),
        .ipb_rdata_i, .ipb_err_ack_i, .ipb_grant_i, .ipb_retry_i(1'b0), .ipb_timeout_i,
        .ipb_xfer_ack_i);
    sbiu_ram_model dram (.clk_i, .slow_i(slow), .addr_i(data_addr_o), .be_i(data_byte_en_o),
        .wdata_i(data_wdata_o), .as_i(data_addr_strobe_o), .wr_i(data_write_strobe_o),
        .rdata_o(data_rdata_i), .ready_o(data_side_ready_i));
    sbiu_ram_model iram (.clk_i, .slow_i(slow), .addr_i(instr_addr_o), .be_i(4'hF),
        .wdata_i(32'h0000_0000), .as_i(instr_addr_strobe_o), .wr_i(1'b0),
        .rdata_o(instr_word_i), .ready_o(instr_side_ready_i));
    sbiu_pb_model dpb (.clk_i, .slow_i(slow), .req_i(dpb_request_o), .sel_i(dpb_select_o),
        .addr_i(dpb_addr_o), .grant_o(dpb_grant_i), .ack_o(dpb_xfer_ack_i),
        .err_o(dpb_err_ack_i), .tout_o(dpb_timeout_i), .rdata_o(dpb_rdata_i));
    sbiu_pb_model ipb (.clk_i, .slow_i(slow), .req_i(ipb_request_o), .sel_i(ipb_select_o),
        .addr_i(ipb_addr_o), .grant_o(ipb_grant_i), .ack_o(ipb_xfer_ack_i),
        .err_o(ipb_err_ack_i), .tout_o(ipb_timeout_i), .rdata_o(ipb_rdata_i));

    always #5 clk_i = ~clk_i;

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Entered at an edge; returns at the edge that took the request, still holding it
    task automatic req(logic side, logic w, logic [31:0] a, logic [1:0] s, logic [31:0] wd,
                       logic [32:0] e);
        logic r;
        #1;
        r = 0;
        if (side) begin
            ireq_valid_i = 1;
            ireq_addr_i = a;
            iq.push_back({1'b1, e});
        end else begin
            dreq_valid_i = 1;
            dreq_write_i = w;
            dreq_addr_i = a;
            dreq_size_i = s;
            dreq_wdata_i = wd;
            dq.push_back({!w, e});
        end
        for (int k = 0; k < 50 && !r; k++) begin
            @(negedge clk_i);
            r = side ? ireq_ready_o === 1'b1 : dreq_ready_o === 1'b1;
            @(posedge clk_i);
        end
        if (!r) bad_count++;
    endtask

    task automatic idle(string name);
        #1;
        dreq_valid_i = 0;
        ireq_valid_i = 0;
        @(posedge clk_i);
        $display("Done %s", name);
    endtask

    always @(posedge clk_i) begin
        logic [33:0] n;
        if (drsp_valid_o === 1'b1) begin
            n = dq.pop_front();
            check("data error flag", 32'(drsp_err_o), 32'(n[32]));
            if (n[33]) check("data read word", drsp_rdata_o, n[31:0]);
        end
        if (irsp_valid_o === 1'b1) begin
            n = iq.pop_front();
            check("fetch error flag", 32'(irsp_err_o), 32'(n[32]));
            check("fetch word", irsp_instr_o, n[31:0]);
            check("fetch port wdata", instr_port_wdata_o, 32'h0000_0000);
            check("fetch port rnw", 32'(instr_port_read_not_write_o), 32'h0000_0001);
        end
    end

    initial begin
        logic [31:0] a, w;
        void'($urandom(32'h74310a2c));
        repeat (6) @(posedge clk_i);
        #1 arst_n_i = 1;
        @(posedge clk_i);
        req(0, 1, 32'h0000_0040, SBIU_SIZE_WORD, 32'h1122_3344, 0);
        for (int k = 0; k < 4; k++) req(0, 1, 32'h40 + k, SBIU_SIZE_BYTE, {4{8'hE0 + 8'(k)}}, 0);
        req(0, 1, 32'h0000_0042, SBIU_SIZE_HALF, 32'hBEEF_BEEF, 0);
        req(0, 0, 32'h0000_0040, SBIU_SIZE_WORD, 0, {1'b0, 32'hE0E1_BEEF});
        req(0, 0, 32'h0000_0043, SBIU_SIZE_BYTE, 0, {1'b0, 32'hE0E1_BEEF});
        idle("lanes");
        for (int k = 0; k < 8; k++) begin
            #1 slow = 1'($urandom);
            a = {22'h0, 8'($urandom), 2'h0};
            w = $urandom;
            req(0, 1, a, SBIU_SIZE_WORD, w, 0);
            req(0, 0, a, SBIU_SIZE_WORD, 0, {1'b0, w});
        end
        idle("random");
        req(0, 0, 32'h0001_0008, SBIU_SIZE_WORD, 0, {1'b0, ~32'h0001_0008});
        req(0, 1, 32'h0001_0010, SBIU_SIZE_WORD, 32'h1234_5678, 0);
        #1 slow = 1;
        req(0, 0, 32'h8000_0020, SBIU_SIZE_WORD, 0, {1'b1, ~32'h8000_0020});
        req(0, 0, 32'h4000_0030, SBIU_SIZE_WORD, 0, {1'b1, ~32'h4000_0030});
        idle("peripheral");
        #1 slow = 0;
        for (int k = 0; k < 4; k++) req(1, 0, 32'(4 * k), 0, 0, {1'b0, {4{8'(k)}} ^ 32'h5A5A_A5A5});
        req(1, 0, 32'h0003_0010, 0, 0, {1'b0, ~32'h0003_0010});
        req(1, 0, 32'h8000_0004, 0, 0, {1'b1, ~32'h8000_0004});
        req(1, 0, 32'h4000_0008, 0, 0, {1'b1, ~32'h4000_0008});
        idle("fetch");
        repeat (10) @(posedge clk_i);
        check("pending answers", dq.size() + iq.size(), 0);
        close_out();
    end

    initial begin
        #100000;
        bad_count++;
        close_out();
    end
endmodule // testbench

`default_nettype wire
